/* File: test/isbi_far_model.sv */
// Bus controller, arbiter and addressed slave seen from the interface.
// Assumes select and ready from the design on the same clock.
`timescale 1ns/1ps
module isbi_far_model (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Reset
  input wire logic system_bus_select, // Cycle decoded
  input wire logic cpuWrite, // Write cycle
  input wire logic readyN, // Ready to processor
  input wire logic [7:0] ackDelay, // Slave response time
  input wire logic [15:0] readData, // Slave read value
  output logic controllerLatchStrobeN, // Latch strobe
  output logic controller_data_enable, // Data enable
  output logic transfer_direction, // High = write
  output logic arbiter_address_enable_n, // Bus owned
  output logic xferAckN, // Acknowledge
  output logic [15:0] sysDataInN // Slave data, active low
);
  logic busy;
  logic seen;
  logic [7:0] cnt;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy <= 1'b0;
      seen <= 1'b0;
      cnt <= 8'h00;
      controllerLatchStrobeN <= 1'b1;
      controller_data_enable <= 1'b0;
      transfer_direction <= 1'b0;
      arbiter_address_enable_n <= 1'b1;
      xferAckN <= 1'b1;
      sysDataInN <= 16'hffff;
    end else if (!busy) begin
      if (system_bus_select) begin
        busy <= 1'b1;
        seen <= 1'b0;
        cnt <= 8'h00;
        arbiter_address_enable_n <= 1'b0;
        controllerLatchStrobeN <= 1'b0;
        transfer_direction <= cpuWrite;
        controller_data_enable <= cpuWrite;
      end
    end else begin
      cnt <= cnt + 8'h01;
      if (cnt == ackDelay) begin
        xferAckN <= 1'b0;
        sysDataInN <= ~readData;
      end
      if (!readyN) seen <= 1'b1;
      // Released lines float to the terminator level
      if (seen && readyN) begin
        xferAckN <= 1'b1;
        sysDataInN <= 16'hffff;
        controllerLatchStrobeN <= 1'b1;
        controller_data_enable <= 1'b0;
        arbiter_address_enable_n <= 1'b1;
        if (!system_bus_select) busy <= 1'b0;
      end
    end
  end
endmodule

/* File: test/isbi_monitor.sv */
// Concurrent checks on the ports of the system bus interface top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module isbi_monitor (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Reset
  input wire logic [isbi_pkg::CPU_ADDR_MSB:2] cpuAddr, // Address
  input wire logic cpuAddrStrobeN, // Cycle start
  input wire logic cpuWrite, // Write cycle
  input wire logic arbiter_address_enable_n, // Arbiter enable
  input wire logic xferAckN, // Acknowledge
  input wire logic bus_size_sixteen_n, // Bus size answer
  input wire logic system_bus_select, // Select
  input wire logic readyN, // Ready
  input wire logic [23:0] sysAddrN, // Address out
  input wire logic sysAddrOe, // Address enable
  input wire logic [15:0] sysDataOutN, // Data out
  input wire logic commandEnable, // Command enable
  input wire logic memReadCmdN, // Read command
  input wire logic memWriteCmdN // Write command
);
  import isbi_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_SEL_DECODE: assert property ($rose(system_bus_select) |->
    !$past(cpuAddrStrobeN) && $past(cpuAddr[25:18]) == WIN_MATCH)
    else $error("select without window hit");
  AST_BUS_SIZE_SIXTEEN_N_SEL: assert property (bus_size_sixteen_n == !system_bus_select)
    else $error("bus size and select disagree");
  AST_SYS_RDY_TWO: assert property ($fell(readyN) && system_bus_select
    |=> !readyN ##1 readyN)
    else $error("system ready not two cycles");
  AST_LOC_RDY_ONE: assert property ($fell(readyN) && !system_bus_select |=> readyN)
    else $error("local ready not one cycle");
  AST_ACK_LAT: assert property ($fell(xferAckN) && system_bus_select
    |-> ##[3:7] $fell(readyN))
    else $error("ready late after acknowledge");
  AST_ACK_FIRST: assert property ($fell(readyN) && system_bus_select
    |-> $past(xferAckN, 3) == 1'b0)
    else $error("ready before acknowledge");
  AST_ADDR_OE: assert property ($rose(sysAddrOe) |->
    $past(arbiter_address_enable_n, 2) == 1'b0)
    else $error("address drive without arbiter");
  AST_CMD_OE: assert property ($rose(commandEnable) |->
    $past(arbiter_address_enable_n, 2) == 1'b0)
    else $error("commands enabled without arbiter");
  AST_WR_CMD: assert property (!memWriteCmdN |-> memReadCmdN && cpuWrite)
    else $error("write command on read");
  AST_RD_CMD: assert property (!memReadCmdN |-> !cpuWrite && system_bus_select)
    else $error("read command on write");
  AST_ADDR_LOAD: assert property (!$stable(sysAddrN) |-> system_bus_select)
    else $error("address moved outside system cycle");
  AST_WDATA: assert property (!$stable(sysDataOutN) |-> system_bus_select && cpuWrite)
    else $error("write data moved outside write");
  // ------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------
  COV_SYS_RD: cover property ($fell(readyN) && system_bus_select && !cpuWrite);
  COV_SYS_WR: cover property ($fell(readyN) && system_bus_select && cpuWrite);
  COV_LOCAL: cover property ($fell(readyN) && !system_bus_select);
endmodule

bind isbi_top isbi_monitor mon_u (.ref_clk, .srst, .cpuAddr, .cpuAddrStrobeN, .cpuWrite,
  .arbiter_address_enable_n, .xferAckN, .bus_size_sixteen_n, .system_bus_select, .readyN,
  .sysAddrN, .sysAddrOe, .sysDataOutN, .commandEnable, .memReadCmdN, .memWriteCmdN);

/* File: test/tb_top.sv */
// Self-checking bench for the system bus interface glue.
// Assumes the far-side model and the bound monitor are compiled.
`timescale 1ns/1ps
module tb_top;
  import isbi_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [CPU_ADDR_MSB:2] cpuAddr = '0;
  logic [3:0] byte_enables_n = 4'hf;
  logic cpuAddrStrobeN = 1'b1;
  logic cpuWrite = 1'b0;
  logic localReadStrobeN = 1'b1;
  logic [15:0] cpuDataIn = 16'h0000;
  logic [15:0] readData = 16'h0000;
  logic [7:0] ackDelay = 8'h08;
  logic controllerLatchStrobeN, controller_data_enable, transfer_direction;
  logic arbiter_address_enable_n, xferAckN, sysAddrOe, byte_high_enable_n;
  logic [15:0] sysDataInN, sysDataOutN, cpuDataOut;
  logic [23:0] sysAddrN;
  logic bus_size_sixteen_n, system_bus_select, readyN, sysDataOe, cpuDataOe;
  logic commandEnable, memReadCmdN, memWriteCmdN, status_zero_n, status_one_n;
  logic controller_mode_strap;
  logic sawRd = 1'b0, sawWr = 1'b0, sawS0 = 1'b0, sawS1 = 1'b0;
  logic [31:0] seed = 32'h45151b86;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  logic [CPU_ADDR_MSB:2] corner [6] = '{24'h3c0000, 24'h3cffff, 24'h3bffff,
    24'h3d0000, 24'h7c0000, 24'h000100};
  logic [3:0] beTab [7] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0};

  isbi_top dut_u (.ref_clk, .srst, .cpuAddr, .byte_enables_n, .cpuAddrStrobeN, .cpuWrite,
    .cpuDataIn, .localReadStrobeN, .controllerLatchStrobeN, .controller_data_enable,
    .transfer_direction, .arbiter_address_enable_n, .xferAckN, .sysDataInN,
    .bus_size_sixteen_n, .system_bus_select, .readyN, .sysAddrN, .sysAddrOe,
    .byte_high_enable_n, .sysDataOutN, .sysDataOe, .cpuDataOut, .cpuDataOe, .commandEnable,
    .memReadCmdN, .memWriteCmdN, .status_zero_n, .status_one_n, .controller_mode_strap);
  isbi_far_model far_u (.ref_clk, .srst, .system_bus_select, .cpuWrite, .readyN, .ackDelay,
    .readData, .controllerLatchStrobeN, .controller_data_enable, .transfer_direction,
    .arbiter_address_enable_n, .xferAckN, .sysDataInN);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Command and status watch, timeout
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (memReadCmdN === 1'b0) sawRd <= 1'b1;
    if (memWriteCmdN === 1'b0) sawWr <= 1'b1;
    if (status_zero_n === 1'b0) sawS0 <= 1'b1;
    if (status_one_n === 1'b0) sawS1 <= 1'b1;
    if (cycles == 30000) begin
      n_fail++;
      results();
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic hitOf(input logic [CPU_ADDR_MSB:2] a);
    logic [25:0] b;
    b = {a, 2'b00};
    return b >= 26'hf00000 && b <= 26'hf3ffff;
  endfunction
  function automatic logic [1:0] lowOf(input logic [3:0] be);
    if (!be[0]) return 2'h0;
    if (!be[1]) return 2'h1;
    if (!be[2]) return 2'h2;
    return 2'h3;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [CPU_ADDR_MSB:2] a, input logic [3:0] be, input logic wr,
    input logic [15:0] d);
    int lat;
    int n;
    logic hit;
    logic [1:0] lo;
    hit = hitOf(a);
    lo = lowOf(be);
    @(posedge ref_clk);
    cpuAddr <= a;
    byte_enables_n <= be;
    cpuWrite <= wr;
    cpuDataIn <= d;
    cpuAddrStrobeN <= 1'b0;
    localReadStrobeN <= wr;
    readData <= 16'(rnd());
    ackDelay <= 8'(6 + rnd() % 20);
    {sawRd, sawWr, sawS0, sawS1} <= 4'h0;
    @(posedge ref_clk);
    cpuAddrStrobeN <= 1'b1;
    lat = 1;
    while (readyN !== 1'b0 && lat < 400) begin
      @(posedge ref_clk);
      lat++;
    end
    chk(bus_size_sixteen_n, !hit);
    chk(system_bus_select, hit);
    chk({sysAddrOe, commandEnable}, {hit, hit});
    if (hit) begin
      chk(xferAckN, 1'b0);
      chk(sysAddrN, 24'(~{a[23:2], lo}));
      chk(byte_high_enable_n, lo[1] ? be[3] : be[1]);
      chk(sysDataOe, wr);
      if (wr) chk(sysDataOutN, 16'(~d));
      else chk(cpuDataOe, 1'b1);
    end else chk(lat, LOCAL_WAIT_STATES + 3);
    n = 0;
    while (readyN === 1'b0 && n < 5) begin
      @(posedge ref_clk);
      n++;
    end
    localReadStrobeN <= 1'b1;
    chk(n, hit ? 2 : 1);
    if (hit && !wr) chk(cpuDataOut, readData);
    chk({sawRd, sawWr}, hit ? {!wr, wr} : 2'b00);
    if (!hit) chk({sawS0, sawS1}, {wr, !wr});
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [CPU_ADDR_MSB:2] a;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      xfer(corner[i % 6], beTab[i % 7], 1'(i / 6), 16'(rnd()));
    end
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      a = r[23:0];
      if (r[31]) a[25:18] = 8'h3c;
      xfer(a, beTab[r[26:24] % 7], r[27], 16'(rnd()));
    end
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk(readyN, 1'b1);
    chk(sysAddrN, 24'hffffff);
    chk(system_bus_select, 1'b0);
    chk(controller_mode_strap, 1'b1);
    xfer(corner[1], beTab[4], 1'b0, 16'h5a3c);
    results();
  end
endmodule

/* File: verilog/isbi_pkg.sv */
// Constants shared by the system bus interface glue logic.
// Assumes a single 125 MHz clock and no software-visible registers.
package isbi_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int ADDR_HOLD_NS = 50;
  localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLAVE_RELEASE_NS = 125;

  // ------------------------------------------------------------
  // Address window decode
  // ------------------------------------------------------------
  localparam int CPU_ADDR_MSB = 25;
  localparam int SYS_ADDR_W = 24;
  localparam int SYS_DATA_W = 16;
  localparam int WIN_FIELD_HI = 25;
  localparam int WIN_FIELD_LO = 18;
  localparam logic [7:0] WIN_MATCH = 8'h3c;

  // ------------------------------------------------------------
  // Wait states
  // ------------------------------------------------------------
  localparam int WAIT_CNT_W = 4;
  localparam logic [3:0] LOCAL_WAIT_STATES = 4'h2;
  localparam logic [3:0] WAIT_FIRST = 4'h1;
  localparam logic [3:0] WAIT_SECOND = 4'h2;
  localparam logic [3:0] HOLD_CNT_INIT = 4'(ADDR_HOLD_CYC);

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic RST_ACTIVE_LOW_OFF = 1'b1;
  localparam logic RST_ACTIVE_HIGH_OFF = 1'b0;
  localparam logic [SYS_ADDR_W-1:0] RST_SYS_ADDR_N = 24'hffffff;
  localparam logic [SYS_DATA_W-1:0] RST_SYS_DATA_N = 16'hffff;
  localparam logic [SYS_DATA_W-1:0] RST_CPU_DATA = 16'h0000;

  // ------------------------------------------------------------
  // Cycle sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ISBI_IDLE = 3'b000,
    ISBI_LOCAL = 3'b001,
    ISBI_SYS_WAIT = 3'b010,
    ISBI_SYS_XFER = 3'b011,
    ISBI_SYS_READY = 3'b100
  } isbi_state_t;

endpackage

/* File: verilog/isbi_sync.sv */
// Two flip-flop synchroniser for a group of level inputs.
// Assumes inputs are asynchronous pins; output is safe on ref_clk.
`timescale 1ns/1ps
module isbi_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] asyncIn, // Pin levels
  output logic [WIDTH-1:0] syncOut // Synchronised levels
);
  logic [WIDTH-1:0] meta_reg;

  // ------------------------------------------------------------
  // First stage read only by second stage
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_reg <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end
endmodule

/* File: verilog/isbi_top.sv */
// Glue between a 32-bit processor local bus and a 16-bit system bus
// reached through an external bus controller and bus arbiter.
// Assumes processor strobes are on ref_clk; controller, arbiter and
// system-bus pins are asynchronous and are synchronised here.
`timescale 1ns/1ps

// Behaviour
// - Only addresses F00000H..F3FFFFH go to the system bus; others stay local.
// - One decode term drives bus-size-sixteen and select from A25..A18.
// - Every system-bus access answers bus-size-sixteen active.
// - Select enables both the bus controller and arbiter on a decoded access.
// - Up to 24 address lines driven inverted, bit n to line n.
// - Byte-high-enable is latched and driven active low to the system bus.
// - Address latched on controller latch strobe each cycle, held after command.
// - Address outputs drive only while arbiter address enable is active.
// - Low 16 data bits pass inverted to system data lines, same numbering.
// - Write data latched only on writes, under strobe; driven under data enable, direction.
// - Read transceivers enabled by local read strobe, not data enable.
// - Two lowest address bits come from the four byte enables.
// - System-bus wait counting starts at controller latch strobe.
// - Acknowledge synchronised; ready follows it by four to five clocks.
// - Half-rate clock made by dividing the clock by two.
// - System ready held two clocks, gated by select and half-rate clock.
// - Ready extension pulse registered after ack, select, half-rate all true.
// - Local ready after counted wait states; first two drive status outputs.
// - Command outputs enabled only while arbiter address enable is active.
// - Read issues memory-read command; write issues memory-write command.
module isbi_top (
  input wire logic ref_clk, // System clock, 125 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic [isbi_pkg::CPU_ADDR_MSB:2] cpuAddr, // Processor address
  input wire logic [3:0] byte_enables_n, // Processor byte enables
  input wire logic cpuAddrStrobeN, // Processor cycle start
  input wire logic cpuWrite, // Processor cycle is a write
  input wire logic [15:0] cpuDataIn, // Processor write data, low half
  input wire logic localReadStrobeN, // Local read strobe
  input wire logic controllerLatchStrobeN, // Controller address latch strobe
  input wire logic controller_data_enable, // Controller data enable
  input wire logic transfer_direction, // Controller direction, high = write
  input wire logic arbiter_address_enable_n, // Arbiter owns the system bus
  input wire logic xferAckN, // System-bus transfer acknowledge
  input wire logic [15:0] sysDataInN, // System data lines, active low
  output logic bus_size_sixteen_n, // 16-bit cycle answer to processor
  output logic system_bus_select, // Selects controller and arbiter
  output logic readyN, // Ready to processor
  output logic [23:0] sysAddrN, // System address lines, active low
  output logic sysAddrOe, // Drive system address lines
  output logic byte_high_enable_n, // System byte-high-enable
  output logic [15:0] sysDataOutN, // System data lines out, active low
  output logic sysDataOe, // Drive system data lines
  output logic [15:0] cpuDataOut, // Read data to processor
  output logic cpuDataOe, // Drive processor data bus
  output logic commandEnable, // Controller command output enable
  output logic memReadCmdN, // Memory-read command
  output logic memWriteCmdN, // Memory-write command
  output logic status_zero_n, // Status output zero
  output logic status_one_n, // Status output one
  output logic controller_mode_strap // Controller mode input
);
  import isbi_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  isbi_state_t state_reg;
  isbi_state_t state_next;
  logic latchStrobeSyncN;
  logic dataEnableSync;
  logic directionSync;
  logic addrEnableSyncN;
  logic ackSyncN;
  logic [15:0] sysDataSyncN;
  logic synced_ack_ready;
  logic ackSeen_reg;
  logic halfRate_reg;
  logic ready_extend_pulse;
  logic writeCycle_reg;
  logic statusOn_reg;
  logic [3:0] holdCnt_reg;
  logic [3:0] waitCount;
  logic wait_state_first;
  logic wait_state_second;
  logic cycleStart;
  logic windowHit;
  logic readyFire;
  logic localDone;
  logic latchNow;
  logic waitStart;
  logic waitClear;
  logic cmdActive;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] low_addr(input logic [3:0] ben);
    if (!ben[0]) begin
      low_addr = 2'h0;
    end else if (!ben[1]) begin
      low_addr = 2'h1;
    end else if (!ben[2]) begin
      low_addr = 2'h2;
    end else begin
      low_addr = 2'h3;
    end
  endfunction

  function automatic logic high_byte_n(input logic [3:0] ben);
    logic [1:0] a;
    a = low_addr(ben);
    high_byte_n = a[1] ? ben[3] : ben[1];
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  isbi_sync #(
    .WIDTH(4),
    .RST_VAL(4'h9)
  ) u_ctl_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .asyncIn({controllerLatchStrobeN, controller_data_enable, transfer_direction,
      arbiter_address_enable_n}),
    .syncOut({latchStrobeSyncN, dataEnableSync, directionSync, addrEnableSyncN})
  );

  isbi_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_ack_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .asyncIn(xferAckN),
    .syncOut(ackSyncN)
  );

  isbi_sync #(
    .WIDTH(16),
    .RST_VAL(RST_SYS_DATA_N)
  ) u_data_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .asyncIn(sysDataInN),
    .syncOut(sysDataSyncN)
  );

  assign synced_ack_ready = !ackSyncN;

  // ------------------------------------------------------------
  // Wait-state generator
  // ------------------------------------------------------------
  isbi_wait_gen u_wait (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(waitStart),
    .clear(waitClear),
    .waitCount(waitCount),
    .waitStateFirst(wait_state_first),
    .waitStateSecond(wait_state_second)
  );

  // ------------------------------------------------------------
  // Decode and sequencing terms
  // ------------------------------------------------------------
  assign cycleStart = state_reg == ISBI_IDLE && !cpuAddrStrobeN;
  assign windowHit = cpuAddr[WIN_FIELD_HI:WIN_FIELD_LO] == WIN_MATCH;
  assign latchNow = state_reg == ISBI_SYS_WAIT && !latchStrobeSyncN
    && holdCnt_reg == 4'h0;
  assign waitStart = (cycleStart && !windowHit) || latchNow;
  assign waitClear = state_reg == ISBI_IDLE && cpuAddrStrobeN;
  assign localDone = state_reg == ISBI_LOCAL && waitCount == LOCAL_WAIT_STATES;
  assign readyFire = state_reg == ISBI_SYS_XFER && ackSeen_reg && system_bus_select
    && halfRate_reg;
  assign cmdActive = state_reg == ISBI_SYS_XFER && !addrEnableSyncN;

  // ------------------------------------------------------------
  // Cycle state machine
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ISBI_IDLE: begin
        if (cycleStart) begin
          state_next = windowHit ? ISBI_SYS_WAIT : ISBI_LOCAL;
        end
      end
      ISBI_LOCAL: begin
        if (localDone) begin
          state_next = ISBI_IDLE;
        end
      end
      ISBI_SYS_WAIT: begin
        if (latchNow) begin
          state_next = ISBI_SYS_XFER;
        end
      end
      ISBI_SYS_XFER: begin
        if (readyFire) begin
          state_next = ISBI_SYS_READY;
        end
      end
      ISBI_SYS_READY: begin
        state_next = ISBI_IDLE;
      end
      default: begin
        state_next = ISBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ISBI_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // Decode outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus_size_sixteen_n <= RST_ACTIVE_LOW_OFF;
      system_bus_select <= RST_ACTIVE_HIGH_OFF;
      writeCycle_reg <= 1'b0;
    end else if (cycleStart) begin
      bus_size_sixteen_n <= !windowHit;
      system_bus_select <= windowHit;
      writeCycle_reg <= cpuWrite;
    end else if (state_reg == ISBI_SYS_READY || localDone) begin
      bus_size_sixteen_n <= RST_ACTIVE_LOW_OFF;
      system_bus_select <= RST_ACTIVE_HIGH_OFF;
    end
  end

  // ------------------------------------------------------------
  // Half-rate clock and ready
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      halfRate_reg <= 1'b0;
    end else begin
      halfRate_reg <= !halfRate_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ackSeen_reg <= 1'b0;
    end else begin
      ackSeen_reg <= synced_ack_ready;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ready_extend_pulse <= 1'b0;
    end else begin
      ready_extend_pulse <= readyFire;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      readyN <= RST_ACTIVE_LOW_OFF;
    end else begin
      readyN <= !(readyFire || (ready_extend_pulse && system_bus_select)
        || localDone);
    end
  end

  // ------------------------------------------------------------
  // Address latch
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sysAddrN <= RST_SYS_ADDR_N;
      byte_high_enable_n <= RST_ACTIVE_LOW_OFF;
    end else if (latchNow) begin
      sysAddrN <= ~{cpuAddr[23:2], low_addr(byte_enables_n)};
      byte_high_enable_n <= high_byte_n(byte_enables_n);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sysAddrOe <= 1'b0;
    end else begin
      sysAddrOe <= !addrEnableSyncN;
    end
  end

  // Blocks a new address load until the hold time after the command
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      holdCnt_reg <= 4'h0;
    end else if (state_reg == ISBI_SYS_READY) begin
      holdCnt_reg <= HOLD_CNT_INIT;
    end else if (holdCnt_reg != 4'h0) begin
      holdCnt_reg <= holdCnt_reg - 4'h1;
    end
  end

  // ------------------------------------------------------------
  // Data latch and transceivers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sysDataOutN <= RST_SYS_DATA_N;
    end else if (latchNow && writeCycle_reg) begin
      sysDataOutN <= ~cpuDataIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sysDataOe <= 1'b0;
    end else begin
      sysDataOe <= writeCycle_reg && system_bus_select && dataEnableSync
        && directionSync && !addrEnableSyncN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cpuDataOut <= RST_CPU_DATA;
      cpuDataOe <= 1'b0;
    end else begin
      cpuDataOut <= ~sysDataSyncN;
      cpuDataOe <= system_bus_select && !writeCycle_reg && !localReadStrobeN;
    end
  end

  // ------------------------------------------------------------
  // Controller command outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      commandEnable <= 1'b0;
      memReadCmdN <= RST_ACTIVE_LOW_OFF;
      memWriteCmdN <= RST_ACTIVE_LOW_OFF;
    end else begin
      commandEnable <= !addrEnableSyncN;
      memReadCmdN <= !(cmdActive && !writeCycle_reg);
      memWriteCmdN <= !(cmdActive && writeCycle_reg);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      controller_mode_strap <= 1'b1;
    end else begin
      controller_mode_strap <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Status outputs from the first two wait states
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      statusOn_reg <= 1'b0;
    end else if (waitStart || wait_state_first) begin
      statusOn_reg <= 1'b1;
    end else if (wait_state_second || waitClear) begin
      statusOn_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_zero_n <= RST_ACTIVE_LOW_OFF;
      status_one_n <= RST_ACTIVE_LOW_OFF;
    end else begin
      status_zero_n <= !(statusOn_reg && writeCycle_reg);
      status_one_n <= !(statusOn_reg && !writeCycle_reg);
    end
  end

endmodule

/* File: verilog/isbi_wait_gen.sv */
// Wait-state counter: flags for the first two wait states after a start pulse.
// Assumes start and clear come from logic on ref_clk.
`timescale 1ns/1ps
module isbi_wait_gen (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic start, // Begin counting, one-cycle pulse
  input wire logic clear, // Stop and clear the count
  output logic [isbi_pkg::WAIT_CNT_W-1:0] waitCount, // Wait states elapsed
  output logic waitStateFirst, // High during first wait state
  output logic waitStateSecond // High during second wait state
);
  import isbi_pkg::*;

  logic running_reg;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || clear) begin
      running_reg <= 1'b0;
      waitCount <= '0;
    end else if (start) begin
      running_reg <= 1'b1;
      waitCount <= '0;
    end else if (running_reg && waitCount != '1) begin
      waitCount <= waitCount + 4'h1;
    end
  end

  assign waitStateFirst = running_reg && waitCount == WAIT_FIRST;
  assign waitStateSecond = running_reg && waitCount == WAIT_SECOND;
endmodule
